// [shared/acst_consts.vh]
// Timing counts, modes and field constants for the converter sequencer.
`ifndef ACST_CONSTS_VH
`define ACST_CONSTS_VH
// Master clock periods per conversion.
`define ACST_CONV_CYCLES 18
// Master clock periods of a full self-calibration.
`define ACST_CAL_FULL_CYCLES 125013
// Master clock periods of the internal DAC plus system full-scale phase.
`define ACST_CAL_GAIN_CYCLES 111114
// Master clock periods of the system offset phase.
`define ACST_CAL_OFFS_CYCLES 13899
// Busy must rise within 2.5 master periods; two whole periods are used.
`define ACST_BUSY_LAT_CYCLES 2
// Calibration kinds.
`define ACST_CAL_FULL 2'h0
`define ACST_CAL_GAIN 2'h1
`define ACST_CAL_OFFS 2'h2
// Result word width.
`define ACST_RES_W 12
// Serial frame length in bits.
`define ACST_FRAME_BITS 16
// Bit index in the serial frame that starts a conversion.
`define ACST_CMD_CONV_BIT 0
`endif

// [verilog/acst_edge.v]
// Two-flop synchroniser with rise and fall detection.
`timescale 1ns/1ps
module acst_edge (
    clk_sys,
    rst,
    async_in,
    level_out,
    rise_out,
    fall_out
);
    parameter RESET_VAL = 1'b0;
    input wire clk_sys;
    input wire rst;
    input wire async_in;
    output wire level_out;
    output wire rise_out;
    output wire fall_out;
    reg meta_q;
    reg sync_q;
    reg last_q;

    // =========================================================
    // Synchroniser
    // The first stage feeds only the second stage, so no logic sees metastability.
    always @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
            last_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edges compare two settled samples.
    assign level_out = sync_q;
    assign rise_out = sync_q & ~last_q;
    assign fall_out = ~sync_q & last_q;
endmodule // acst_edge

// [verilog/acst_top.v]
// Conversion and calibration sequencer with framed serial port.
`timescale 1ns/1ps
`include "acst_consts.vh"
module acst_top (
    clk_sys,
    rst,
    master_clock_in,
    conv_start_n,
    cal_start,
    cal_kind,
    mode_sel,
    polarity,
    frame_sel_n,
    sclk_in,
    sclk_out,
    sclk_oe_n,
    din_in,
    din_out,
    din_oe_n,
    dout_out,
    dout_oe_n,
    sample_data,
    busy,
    result
);
    parameter CAL_FULL = `ACST_CAL_FULL_CYCLES;
    parameter CAL_GAIN = `ACST_CAL_GAIN_CYCLES;
    parameter CAL_OFFS = `ACST_CAL_OFFS_CYCLES;
    parameter RES_W = `ACST_RES_W;
    parameter FRAME_BITS = `ACST_FRAME_BITS;
    input wire clk_sys;
    input wire rst;
    input wire master_clock_in;
    input wire conv_start_n;
    input wire cal_start;
    input wire [1:0] cal_kind;
    input wire [2:0] mode_sel;
    input wire polarity;
    input wire frame_sel_n;
    input wire sclk_in;
    output reg sclk_out;
    output wire sclk_oe_n;
    input wire din_in;
    output reg din_out;
    output reg din_oe_n;
    output reg dout_out;
    output reg dout_oe_n;
    input wire [RES_W-1:0] sample_data;
    output reg busy;
    output reg [RES_W-1:0] result;

    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_CAL = 2'h2;
    localparam ST_ARM = 2'h3;

    wire mclk_rise;
    wire cs_fall;
    wire cal_rise;
    wire fs_low;
    wire fs_fall;
    wire fs_rise;
    wire fs_n_lvl;
    wire mclk_lvl;
    wire mclk_fall;
    wire din_lvl;
    wire sclk_r;
    wire sclk_f;
    wire pol_lvl;
    wire [2:0] mode_q;
    reg [2:0] mode_s1_q;
    reg [2:0] mode_s2_q;
    reg [1:0] kind_s1_q;
    reg [1:0] kind_s2_q;
    reg [1:0] st_q;
    reg [16:0] cnt_q;
    reg [16:0] cal_len_q;
    reg [1:0] lat_q;
    reg [FRAME_BITS-1:0] sh_out_q;
    reg [FRAME_BITS-1:0] sh_in_q;
    reg [4:0] bit_q;
    reg soft_conv_q;
    wire self_clk;
    wire launch_edge;
    wire sample_edge;

    // =========================================================
    // Input synchronisers
    acst_edge #(.RESET_VAL(1'b0)) u_mclk (.clk_sys(clk_sys), .rst(rst),
        .async_in(master_clock_in),
        .level_out(mclk_lvl), .rise_out(mclk_rise), .fall_out(mclk_fall));
    acst_edge #(.RESET_VAL(1'b1)) u_cs (.clk_sys(clk_sys), .rst(rst),
        .async_in(conv_start_n), .level_out(), .rise_out(), .fall_out(cs_fall));
    acst_edge #(.RESET_VAL(1'b0)) u_cal (.clk_sys(clk_sys), .rst(rst),
        .async_in(cal_start), .level_out(), .rise_out(cal_rise), .fall_out());
    acst_edge #(.RESET_VAL(1'b1)) u_fs (.clk_sys(clk_sys), .rst(rst),
        .async_in(frame_sel_n), .level_out(fs_n_lvl), .rise_out(fs_rise), .fall_out(fs_fall));
    acst_edge #(.RESET_VAL(1'b1)) u_sclk (.clk_sys(clk_sys), .rst(rst),
        .async_in(sclk_in), .level_out(), .rise_out(sclk_r), .fall_out(sclk_f));
    acst_edge #(.RESET_VAL(1'b0)) u_din (.clk_sys(clk_sys), .rst(rst),
        .async_in(din_in), .level_out(din_lvl), .rise_out(), .fall_out());
    acst_edge #(.RESET_VAL(1'b1)) u_pol (.clk_sys(clk_sys), .rst(rst),
        .async_in(polarity), .level_out(pol_lvl), .rise_out(), .fall_out());

    // Straps are slow levels; a plain two-flop pass is enough.
    always @(posedge clk_sys) begin
        if (rst) begin
            mode_s1_q <= 3'h1;
            mode_s2_q <= 3'h1;
            kind_s1_q <= 2'h0;
            kind_s2_q <= 2'h0;
        end else begin
            mode_s1_q <= mode_sel;
            mode_s2_q <= mode_s1_q;
            kind_s1_q <= cal_kind;
            kind_s2_q <= kind_s1_q;
        end
    end
    assign mode_q = mode_s2_q;
    // The frame select pin is active low; fs_low marks an open frame.
    assign fs_low = ~fs_n_lvl;

    // =========================================================
    // Serial clock source and edge roles
    assign self_clk = (mode_q == 3'h4) || (mode_q == 3'h5);
    assign sclk_oe_n = ~self_clk;

    // Self clock copies the synchronised master level, so it runs at master rate.
    // It runs free in modes four and five; frame select alone marks the words.
    always @(posedge clk_sys) begin
        if (rst) begin
            sclk_out <= 1'b0;
        end else begin
            sclk_out <= self_clk & mclk_lvl;
        end
    end

    // With the host clock the mode 1-3 rate limit is the host's duty.
    // Polarity low swaps which edge launches and which samples.
    assign launch_edge = self_clk ? (pol_lvl ? mclk_fall : mclk_rise) :
        (pol_lvl ? sclk_f : sclk_r);
    assign sample_edge = self_clk ? (pol_lvl ? mclk_rise : mclk_fall) :
        (pol_lvl ? sclk_r : sclk_f);

    // =========================================================
    // Conversion and calibration sequencer
    always @(posedge clk_sys) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 17'h0_0000;
            cal_len_q <= 17'h0_0000;
            lat_q <= 2'h0;
            busy <= 1'b0;
            result <= {RES_W{1'b0}};
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (cal_rise) begin
                        busy <= 1'b1;
                        st_q <= ST_CAL;
                        cnt_q <= 17'h0_0000;
                        case (kind_s2_q)
                            `ACST_CAL_GAIN: cal_len_q <= CAL_GAIN[16:0];
                            `ACST_CAL_OFFS: cal_len_q <= CAL_OFFS[16:0];
                            default: cal_len_q <= CAL_FULL[16:0];
                        endcase
                    end else if (cs_fall || soft_conv_q) begin
                        busy <= 1'b1;
                        st_q <= ST_CONV;
                        cnt_q <= 17'h0_0000;
                    end
                end
                ST_CONV: begin
                    if (mclk_rise) begin
                        cnt_q <= cnt_q + 17'h0_0001;
                        if (cnt_q == `ACST_CONV_CYCLES - 1) begin
                            busy <= 1'b0;
                            result <= sample_data;
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_CAL: begin
                    // A start pulse during calibration re-arms busy quickly.
                    if (cs_fall) begin
                        st_q <= ST_ARM;
                        lat_q <= 2'h0;
                    end
                    if (mclk_rise) begin
                        cnt_q <= cnt_q + 17'h0_0001;
                        if (cnt_q == cal_len_q - 17'h0_0001) begin
                            busy <= 1'b0;
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_ARM: begin
                    // Busy is already high; counting goes on, and ST_CAL returns after two master rises.
                    busy <= 1'b1;
                    if (mclk_rise) begin
                        lat_q <= lat_q + 2'h1;
                        cnt_q <= cnt_q + 17'h0_0001;
                    end
                    if (lat_q == `ACST_BUSY_LAT_CYCLES) begin
                        st_q <= ST_CAL;
                    end
                    // The sequence may run out while re-armed; it must still end.
                    if (mclk_rise && cnt_q == cal_len_q - 17'h0_0001) begin
                        busy <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // Framed serial port
    // The result shifts out MSB first; host bits shift in for the command word.
    always @(posedge clk_sys) begin
        if (rst) begin
            dout_oe_n <= 1'b1;
            din_oe_n <= 1'b1;
            dout_out <= 1'b0;
            din_out <= 1'b0;
            sh_out_q <= {FRAME_BITS{1'b0}};
            sh_in_q <= {FRAME_BITS{1'b0}};
            bit_q <= 5'h00;
            soft_conv_q <= 1'b0;
        end else begin
            soft_conv_q <= 1'b0;
            if (fs_fall) begin
                dout_oe_n <= 1'b0;
                din_oe_n <= 1'b0;
                sh_out_q <= {{(FRAME_BITS-RES_W){1'b0}}, result};
                bit_q <= 5'h00;
            end else if (fs_rise) begin
                dout_oe_n <= 1'b1;
                din_oe_n <= 1'b1;
                if (bit_q == FRAME_BITS) begin
                    soft_conv_q <= sh_in_q[`ACST_CMD_CONV_BIT];
                end
            end else if (fs_low) begin
                if (launch_edge) begin
                    dout_out <= sh_out_q[FRAME_BITS-1];
                    din_out <= sh_out_q[FRAME_BITS-1];
                    sh_out_q <= {sh_out_q[FRAME_BITS-2:0], 1'b0};
                end
                if (sample_edge) begin
                    sh_in_q <= {sh_in_q[FRAME_BITS-2:0], din_lvl};
                    if (bit_q != FRAME_BITS) begin
                        bit_q <= bit_q + 5'h01;
                    end
                    // The shared line returns to input once the frame's last bit is in.
                    if (bit_q == FRAME_BITS - 1) begin
                        din_oe_n <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // acst_top

// [tb/acst_monitor.sv]
// Checker for busy timing and serial driver enables of the sequencer.
`timescale 1ns/1ps
module acst_monitor #(parameter RES_W = 12) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic conv_start_n,
    input wire logic cal_start,
    input wire logic [2:0] mode_sel,
    input wire logic frame_sel_n,
    input wire logic sclk_oe_n,
    input wire logic din_oe_n,
    input wire logic dout_oe_n,
    input wire logic busy,
    input wire logic [RES_W-1:0] result
);
    // ==========
    // Timing relations.
    // Inputs pass a synchroniser, so each bound allows a few edges of delay.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_conv_busy_rise: assert property (!busy && $fell(conv_start_n) |-> ##[1:6] busy)
        else $error("busy late after conversion start");
    a_cal_busy_rise: assert property (!busy && $rose(cal_start) |-> ##[1:10] busy)
        else $error("busy late after calibration start");
    a_busy_min_hold: assert property ($rose(busy) |-> busy[*8])
        else $error("busy dropped too early");
    a_dout_drive_on: assert property ($fell(frame_sel_n) |-> ##[1:5] !dout_oe_n)
        else $error("data output not driven in frame");
    a_dout_release: assert property ($rose(frame_sel_n) |-> ##[1:5] dout_oe_n)
        else $error("data output not released");
    a_din_drive_on: assert property ($fell(frame_sel_n) |-> ##[1:5] !din_oe_n)
        else $error("data input driver not enabled");
    a_self_clock_oe: assert property ((mode_sel == 3'h4)[*3] |-> !sclk_oe_n)
        else $error("self clock not driven");
    a_result_at_end: assert property ($changed(result) |-> ##[0:3] !busy)
        else $error("result changed mid sequence");
endmodule // acst_monitor

// [tb/acst_host_model.sv]
// Host serial port model: frames, clocks and exchanges one 16-bit word.
`timescale 1ns/1ps
module acst_host_model (
    input wire logic go,
    input wire logic [15:0] tx,
    input wire logic pol,
    input wire logic dout_out,
    output logic frame_sel_n,
    output logic sclk_in,
    output logic din_in,
    output logic [15:0] rx,
    output logic done
);
    int i;
    initial begin
        frame_sel_n = 1'b1;
        sclk_in = 1'b1;
        din_in = 1'b0;
        rx = 16'h0000;
        done = 1'b1;
    end
    // The clock stands still between frames; 320 ns period keeps under 4 MHz.
    always @(posedge go) begin
        done = 1'b0;
        sclk_in = pol;
        // The extra 10 ns keeps every pin change off the sampling clock edge.
        #170 frame_sel_n = 1'b0;
        for (i = 15; i >= 0; i = i - 1) begin
            #160 sclk_in = !pol;
            din_in = tx[i];
            #160 sclk_in = pol;
            rx[i] = dout_out;
        end
        #160 frame_sel_n = 1'b1;
        din_in = !din_in;
        done = 1'b1;
    end
endmodule // acst_host_model

// [tb/tb_top.sv]
// Self-checking bench for the converter sequencer and its serial port.
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic c; logic [1:0] k; int n; logic mid;} acst_row_t;
    localparam int CF = 20, CG = 15, CO = 5;
    logic clk_sys = 0, rst = 1, master_clock_in = 0, conv_start_n = 1, cal_start = 0;
    logic polarity = 1, go = 0, sclk_out, sclk_oe_n, din_out, din_oe_n, dout_out, dout_oe_n;
    logic sclk_in, frame_sel_n, din_in, busy, done;
    logic [1:0] cal_kind = 2'h0;
    logic [2:0] mode_sel = 3'h1;
    logic [11:0] sample_data = 12'h000, result;
    logic [15:0] tx = 16'h0000, rx;
    int n_fail = 0, n_compared = 0;
    acst_row_t rows [6] = '{'{1'b0, 2'h0, 18, 1'b0}, '{1'b0, 2'h0, 18, 1'b1},
        '{1'b1, 2'h0, CF, 1'b0}, '{1'b1, 2'h1, CG, 1'b0}, '{1'b1, 2'h2, CO, 1'b0},
        '{1'b1, 2'h0, CF, 1'b1}};
    // ==========
    // Clocks: master clock is four system periods, unrelated to sampling.
    always #20 clk_sys = !clk_sys;
    always #80 master_clock_in = !master_clock_in;
    acst_top #(.CAL_FULL(CF), .CAL_GAIN(CG), .CAL_OFFS(CO)) DUT (.clk_sys(clk_sys),
        .rst(rst), .master_clock_in(master_clock_in), .conv_start_n(conv_start_n),
        .cal_start(cal_start), .cal_kind(cal_kind), .mode_sel(mode_sel),
        .polarity(polarity), .frame_sel_n(frame_sel_n), .sclk_in(sclk_in),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .din_in(din_in), .din_out(din_out),
        .din_oe_n(din_oe_n), .dout_out(dout_out), .dout_oe_n(dout_oe_n),
        .sample_data(sample_data), .busy(busy), .result(result));
    acst_host_model HOST (.go(go), .tx(tx), .pol(polarity), .dout_out(dout_out),
        .frame_sel_n(frame_sel_n), .sclk_in(sclk_in), .din_in(din_in), .rx(rx), .done(done));
    task automatic chk(input bit ok, input string m);
        n_compared++;
        if (!ok) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Start on a master rise so busy length is measured at a fixed phase.
    task automatic run_op(input logic c, input logic [1:0] k, input logic mid, output int cyc);
        int w;
        @(posedge master_clock_in);
        @(posedge clk_sys);
        cal_kind <= k;
        if (c) cal_start <= 1'b1;
        else conv_start_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cal_start <= 1'b0;
        conv_start_n <= 1'b1;
        w = 0;
        cyc = 0;
        while (busy !== 1'b1 && w < 16) begin
            @(posedge clk_sys);
            w++;
        end
        while (busy === 1'b1 && cyc < 500) begin
            @(posedge clk_sys);
            cyc++;
            if (mid && cyc == 30) conv_start_n <= 1'b0;
            if (cyc == 33) conv_start_n <= 1'b1;
        end
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic frame(input logic [15:0] w);
        int t;
        tx <= w;
        go <= 1'b1;
        t = 0;
        @(posedge clk_sys);
        while (done !== 1'b1 && t < 400) begin
            @(posedge clk_sys);
            t++;
        end
        go <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Main sequence: table of timed operations, then hand-written cases.
    initial begin
        int cyc, t;
        logic s;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(busy === 1'b0 && dout_oe_n === 1'b1 && din_oe_n === 1'b1, "reset state");
        foreach (rows[i]) begin
            run_op(rows[i].c, rows[i].k, rows[i].mid, cyc);
            t = rows[i].c ? 10 : 3;
            chk(cyc - 4 * rows[i].n <= t && 4 * rows[i].n - cyc <= t, "busy length");
        end
        for (int p = 1; p >= 0; p--) begin
            polarity <= p[0];
            sample_data <= p[0] ? 12'hA5C : 12'h3C1;
            run_op(1'b0, 2'h0, 1'b0, cyc);
            frame(16'h0000);
            chk(rx === {4'h0, sample_data}, "serial word");
        end
        polarity <= 1'b1;
        frame(16'h0001);
        t = 0;
        while (busy !== 1'b1 && t < 10) begin
            @(posedge clk_sys);
            t++;
        end
        chk(busy === 1'b1, "command start");
        repeat (100) @(posedge clk_sys);
        mode_sel <= 3'h4;
        repeat (4) @(posedge clk_sys);
        s = sclk_out;
        t = 0;
        repeat (16) begin
            @(posedge clk_sys);
            if (sclk_out !== s) t++;
            s = sclk_out;
        end
        chk(sclk_oe_n === 1'b0 && t >= 6 && t <= 10, "self clock");
        mode_sel <= 3'h1;
        repeat (4) @(posedge clk_sys);
        chk(sclk_oe_n === 1'b1, "self clock off");
        // Reset in mid conversion must drop busy and leave no false start behind.
        conv_start_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(busy === 1'b1, "busy before reset");
        conv_start_n <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(busy === 1'b0 && dout_oe_n === 1'b1, "reset mid run");
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(busy === 1'b0, "no start after reset");
        tally_and_finish();
    end
    // Watchdog well beyond the roughly 1200 cycles the sequence needs.
    initial begin
        #400_000;
        n_fail++;
        tally_and_finish();
    end
endmodule // tb_top
bind acst_top acst_monitor #(.RES_W(RES_W)) MON (.clk_sys(clk_sys), .rst(rst),
    .conv_start_n(conv_start_n), .cal_start(cal_start), .mode_sel(mode_sel),
    .frame_sel_n(frame_sel_n), .sclk_oe_n(sclk_oe_n), .din_oe_n(din_oe_n),
    .dout_oe_n(dout_oe_n), .busy(busy), .result(result));
